// [include/msf_defines.svh]
// Purpose: Offsets, bit positions and reset values of the metering status flags
// Assumes: 16-bit register words on the serial register port
// Notes: Definitions only
`ifndef MSF_DEFINES_SVH
`define MSF_DEFINES_SVH

`define MSF_STATUS_ADDR 10'h001
`define MSF_STATUS_RESET 16'h0000
`define MSF_BIT_GRP0_CS 14
`define MSF_BIT_GRP1_CS 12
`define MSF_BIT_GRP2_CS 10
`define MSF_BIT_GRP3_CS 8
`define MSF_BIT_VSEQ 7
`define MSF_BIT_ISEQ 6
`define MSF_BIT_DIP 3
`define MSF_BIT_PLOSS 2
`define MSF_LIVE_MASK 16'h55cc
`define MSF_CS_MASK 16'h5500

`endif

// [include/msf_pkg.sv]
// Purpose: Types of the metering status flags block
// Assumes: Constants come from msf_defines.svh
// Notes: State is one packed struct
`default_nettype none
package msf_pkg;

    typedef struct packed {
        logic [15:0] flags;
        logic [15:0] rdata;
        logic rvalid;
        logic irq;
        logic warn;
    } msf_state_type;

endpackage

`default_nettype wire

// [logic/msf_status_flags.sv]
// Purpose: Read-to-clear system status flags with interrupt and warning pins
// Assumes: Detector and checksum inputs are levels synchronous to clock
// Notes: Enable register layout lives outside; its 16 bits arrive as a port
`timescale 1ns/1ps
`default_nettype none
`include "msf_defines.svh"

module msf_status_flags
    import msf_pkg::*;
#(
    parameter int ADDR_W = 10
)
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic reg_rd,
    input wire logic [ADDR_W-1:0] reg_addr,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [15:0] first_function_enable,
    input wire logic group0_checksum_error,
    input wire logic group1_checksum_error,
    input wire logic group2_checksum_error,
    input wire logic group3_checksum_error,
    input wire logic voltage_sequence_error,
    input wire logic current_sequence_error,
    input wire logic voltage_dip_detect,
    input wire logic phase_loss_detect,
    output logic first_interrupt_pin,
    output logic warning_output_pin
);

    // Refused at elaboration: the register map needs at least nine address bits
    if (ADDR_W < 9 || ADDR_W > 16)
    begin : g_addr_w_check
        $error("ADDR_W must lie between 9 and 16");
    end

    msf_state_type st_r;
    msf_state_type st_nxt;
    logic [15:0] cond;
    logic status_rd;

    // Map detector levels onto their flag positions
    function automatic logic [15:0] cond_vec(
        input logic g0,
        input logic g1,
        input logic g2,
        input logic g3,
        input logic vs,
        input logic is,
        input logic dip,
        input logic pl
    );
        logic [15:0] v;
        v = 16'h0000;
        v[`MSF_BIT_GRP0_CS] = g0;
        v[`MSF_BIT_GRP1_CS] = g1;
        v[`MSF_BIT_GRP2_CS] = g2;
        v[`MSF_BIT_GRP3_CS] = g3;
        v[`MSF_BIT_VSEQ] = vs;
        v[`MSF_BIT_ISEQ] = is;
        v[`MSF_BIT_DIP] = dip;
        v[`MSF_BIT_PLOSS] = pl;
        return v & `MSF_LIVE_MASK;
    endfunction

    function automatic logic any_set(
        input logic [15:0] vec,
        input logic [15:0] mask
    );
        return |(vec & mask);
    endfunction

    assign cond = cond_vec(group0_checksum_error, group1_checksum_error,
        group2_checksum_error, group3_checksum_error, voltage_sequence_error,
        current_sequence_error, voltage_dip_detect, phase_loss_detect);
    assign status_rd = reg_rd && (reg_addr == ADDR_W'(`MSF_STATUS_ADDR));

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.rvalid = reg_rd;
        if (reg_rd)
        begin
            // Other addresses belong to other blocks and answer zero here
            st_nxt.rdata = status_rd ? st_r.flags : 16'h0000;
        end
        // Set wins over the clearing read so no event is lost
        st_nxt.flags = ((status_rd ? 16'h0000 : st_r.flags) | cond)
            & `MSF_LIVE_MASK;
        st_nxt.irq = any_set(st_nxt.flags, first_function_enable);
        st_nxt.warn = any_set(st_nxt.flags, `MSF_CS_MASK);
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            st_r.flags <= `MSF_STATUS_RESET;
            st_r.rdata <= 16'h0000;
            st_r.rvalid <= 1'b0;
            st_r.irq <= 1'b0;
            st_r.warn <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign reg_rvalid = st_r.rvalid;
    assign first_interrupt_pin = st_r.irq;
    assign warning_output_pin = st_r.warn;

    // Assertions
    sequence s_status_read;
        reg_rd && reg_addr == ADDR_W'(`MSF_STATUS_ADDR);
    endsequence

    sequence s_no_cond;
        cond == 16'h0000;
    endsequence

    property p_read_returns;
        @(posedge clock) disable iff (sys_rst)
        s_status_read |=> reg_rvalid && reg_rdata == $past(st_r.flags);
    endproperty
    a_read_returns: assert property (p_read_returns)
        else $error("Status read did not return held flags");

    property p_read_clears;
        @(posedge clock) disable iff (sys_rst)
        s_status_read ##0 s_no_cond |=> st_r.flags == 16'h0000;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("Status read did not clear flags");

    property p_reset_zero;
        @(posedge clock) sys_rst |=> st_r.flags == 16'h0000 && !first_interrupt_pin
            && !warning_output_pin;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("Flags not zero after reset");

    property p_grp0_sets;
        @(posedge clock) disable iff (sys_rst)
        group0_checksum_error |=> st_r.flags[`MSF_BIT_GRP0_CS];
    endproperty
    a_grp0_sets: assert property (p_grp0_sets)
        else $error("Group zero checksum flag missed");

    property p_cs_warn;
        @(posedge clock) disable iff (sys_rst)
        (group1_checksum_error || group2_checksum_error || group3_checksum_error)
            |=> warning_output_pin && (st_r.flags & `MSF_CS_MASK) != 16'h0000;
    endproperty
    a_cs_warn: assert property (p_cs_warn)
        else $error("Checksum error did not raise warning with its flag");

    property p_warn_cause;
        @(posedge clock) disable iff (sys_rst)
        warning_output_pin |-> (st_r.flags & `MSF_CS_MASK) != 16'h0000;
    endproperty
    a_warn_cause: assert property (p_warn_cause)
        else $error("Warning pin without checksum flag");

    property p_seq_flags;
        @(posedge clock) disable iff (sys_rst)
        (voltage_sequence_error |=> st_r.flags[`MSF_BIT_VSEQ])
            and (current_sequence_error |=> st_r.flags[`MSF_BIT_ISEQ]);
    endproperty
    a_seq_flags: assert property (p_seq_flags)
        else $error("Phase sequence flag missed");

    property p_dip_loss;
        @(posedge clock) disable iff (sys_rst)
        (voltage_dip_detect |=> st_r.flags[`MSF_BIT_DIP])
            and (phase_loss_detect |=> st_r.flags[`MSF_BIT_PLOSS]);
    endproperty
    a_dip_loss: assert property (p_dip_loss)
        else $error("Dip or phase loss flag missed");

    property p_irq;
        @(posedge clock) disable iff (sys_rst)
        first_interrupt_pin == ((st_r.flags & $past(first_function_enable)) != 16'h0000);
    endproperty
    a_irq: assert property (p_irq)
        else $error("Interrupt pin does not match enabled flags");

    property p_reserved;
        @(posedge clock) disable iff (sys_rst)
        (st_r.flags & ~`MSF_LIVE_MASK) == 16'h0000;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("Reserved status bit set");

    property p_resets_again;
        @(posedge clock) disable iff (sys_rst)
        s_status_read |=> st_r.flags == $past(cond);
    endproperty
    a_resets_again: assert property (p_resets_again)
        else $error("Persisting condition lost at clearing read");

endmodule

`default_nettype wire

// [test/msf_host_model.sv]
// Purpose: Host controller reading status words over the register port
// Assumes: Calls are made from falling-edge stimulus
// Notes: Idle address shows the inverse of the last one, never a stale copy
`timescale 1ns/1ps
`default_nettype none
module msf_host_model (
    input wire logic clock,
    output logic reg_rd,
    output logic [9:0] reg_addr,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial
    begin
        reg_rd = 1'b0;
        reg_addr = 10'h000;
    end
    task automatic read(input logic [9:0] a, output logic [15:0] d);
        @(negedge clock);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clock);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = (reg_rvalid === 1'b1) ? reg_rdata : 16'hxxxx;
    endtask
endmodule
`default_nettype wire

// [test/test_metering_status_flags.sv]
// Purpose: Self-checking bench of the status flags
// Assumes: Inputs change on the falling edge
// Notes: Enable register is a plain port here
`timescale 1ns/1ps
`default_nettype none
`include "msf_defines.svh"
module test_metering_status_flags;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] en = 16'h0000;
    logic [7:0] cond = 8'h00;
    logic reg_rd;
    logic [9:0] reg_addr;
    logic [15:0] reg_rdata;
    logic reg_rvalid;
    logic irq;
    logic warn;
    logic [15:0] d;
    int mismatches = 0;
    int compares = 0;
    int pos [8] = '{14, 12, 10, 8, 7, 6, 3, 2};
    always #4 clock = ~clock;
    msf_status_flags i_dut (.clock, .sys_rst, .reg_rd, .reg_addr, .reg_rdata, .reg_rvalid,
        .first_function_enable(en), .group0_checksum_error(cond[0]),
        .group1_checksum_error(cond[1]), .group2_checksum_error(cond[2]),
        .group3_checksum_error(cond[3]), .voltage_sequence_error(cond[4]),
        .current_sequence_error(cond[5]), .voltage_dip_detect(cond[6]),
        .phase_loss_detect(cond[7]), .first_interrupt_pin(irq), .warning_output_pin(warn));
    msf_host_model i_host (.clock, .reg_rd, .reg_addr, .reg_rdata, .reg_rvalid);
    task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] s);
        compares++;
        if (s !== e)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic chk1(input string n, input logic e, input logic s);
        chk16(n, {15'h0000, e}, {15'h0000, s});
    endtask
    task automatic tally_and_finish;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic t_reset;
        chk1("irq", 1'b0, irq);
        i_host.read(`MSF_STATUS_ADDR, d);
        chk16("reset", 16'h0000, d);
    endtask
    task automatic t_flags;
        for (int i = 0; i < 8; i++)
        begin
            en = 16'h0001 << pos[i];
            cond = 8'h01 << i;
            @(negedge clock);
            cond = 8'h00;
            chk1("warn", i < 4, warn);
            chk1("irq", 1'b1, irq);
            i_host.read(`MSF_STATUS_ADDR, d);
            chk16("flag", 16'h0001 << pos[i], d);
            chk1("irq", 1'b0, irq);
            chk1("warn", 1'b0, warn);
            i_host.read(`MSF_STATUS_ADDR, d);
            chk16("clear", 16'h0000, d);
        end
    endtask
    task automatic t_hold;
        en = 16'h0000;
        cond = 8'hff;
        repeat (2) @(negedge clock);
        chk1("irq", 1'b0, irq);
        en = 16'hffff;
        @(negedge clock);
        chk1("irq", 1'b1, irq);
        repeat (2)
        begin
            i_host.read(`MSF_STATUS_ADDR, d);
            chk16("live", 16'h55cc, d);
        end
        cond = 8'h00;
        i_host.read(10'h002, d);
        chk16("unmapped", 16'h0000, d);
        i_host.read(`MSF_STATUS_ADDR, d);
        chk16("last", 16'h55cc, d);
        i_host.read(`MSF_STATUS_ADDR, d);
        chk16("empty", 16'h0000, d);
    endtask
    task automatic t_midreset;
        en = 16'hffff;
        cond = 8'h0f;
        @(negedge clock);
        cond = 8'h00;
        chk1("warn", 1'b1, warn);
        chk1("irq", 1'b1, irq);
        sys_rst = 1'b1;
        repeat (2) @(negedge clock);
        chk1("irq", 1'b0, irq);
        chk1("warn", 1'b0, warn);
        sys_rst = 1'b0;
        i_host.read(`MSF_STATUS_ADDR, d);
        chk16("rereset", 16'h0000, d);
    endtask
    initial
    begin
        repeat (10) @(negedge clock);
        sys_rst = 1'b0;
        t_reset;
        t_flags;
        t_hold;
        t_midreset;
        tally_and_finish;
    end
    initial
    begin
        #20000;
        mismatches++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
